// ---- logic/lmm_map.vh ----
`ifndef LMM_MAP_VH
`define LMM_MAP_VH
// register offsets
`define LMM_ADDR_LIN_MASK 8'h23
`define LMM_ADDR_MEAS_SEL 8'h24
`define LMM_ADDR_LOAD_HI 8'h25
`define LMM_ADDR_LOAD_LO 8'h26
// flag, status and ready registers, and the ready mask
`define LMM_ADDR_LIN_FLAGS 8'h27
`define LMM_ADDR_LIN_STAT 8'h28
`define LMM_ADDR_MEAS_FLAG 8'h29
`define LMM_ADDR_MEAS_MASK 8'h2a
// mask fields
`define LMM_BIT_L1_FALL 7
`define LMM_BIT_L1_RISE 6
`define LMM_BIT_L1_OC 4
`define LMM_BIT_L0_FALL 3
`define LMM_BIT_L0_RISE 2
`define LMM_BIT_L0_OC 0
`define LMM_LIN_MASK_WMASK 8'hdd
// flag and status fields
`define LMM_BIT_L1_PG 3
`define LMM_BIT_L0_PG 2
`define LMM_BIT_L1_OCF 1
`define LMM_BIT_L0_OCF 0
// reset values
`define LMM_RST_LIN_MASK 8'h00
`define LMM_RST_MEAS_SEL 8'h00
`define LMM_RST_LOAD 9'h000
// measurement timing
`define LMM_MEAS_CYCLES 8'h40
`endif

// ---- logic/lmm_edge_flag.v ----
`timescale 1ns/1ps
// one sticky flag with edge detection and masking
module lmm_edge_flag (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // event source
    input wire level_in,
    input wire rise_mask,
    input wire fall_mask,
    // software clear
    input wire clr,
    // flag
    output reg flag_ff
);
    reg prev_ff;
    wire hit;
    assign hit = (level_in & ~prev_ff & ~rise_mask) | (~level_in & prev_ff & ~fall_mask);
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            // track the pin so release gives no false edge
            prev_ff <= level_in;
            flag_ff <= 1'h0;
        end
        else
        begin
            prev_ff <= level_in;
            // set wins over clear
            if (hit)
                flag_ff <= 1'h1;
            else if (clr)
                flag_ff <= 1'h0;
        end
    end
endmodule // lmm_edge_flag

// ---- logic/lmm_top.v ----
`timescale 1ns/1ps
`include "lmm_map.vh"
module lmm_top (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // regulator live conditions
    input wire lin0_pg_in,
    input wire lin1_pg_in,
    input wire lin0_oc_in,
    input wire lin1_oc_in,
    // buck current samples, 9 bits at 20 mA per count
    input wire [8:0] buck0_cur,
    input wire [8:0] buck1_cur,
    input wire buck_dual_phase,
    input wire buck1_is_master,
    // interrupt and measurement state
    output reg irq_ff,
    output reg meas_busy_ff
);
    // measurement states
    localparam ST_IDLE = 1'h0;
    localparam ST_RUN = 1'h1;

    // register file
    reg [7:0] lin_mask_ff;
    reg [7:0] meas_sel_ff;
    reg [8:0] load_ff;
    reg meas_flag_ff;
    reg meas_mask_ff;
    // measurement engine
    reg state_ff;
    reg [7:0] cnt_ff;
    reg [15:0] acc_ff;
    reg sel_ff;
    // next values
    reg nxt_state;
    reg [7:0] nxt_cnt;
    reg [15:0] nxt_acc;
    reg [8:0] nxt_load;
    reg nxt_meas_flag;
    reg nxt_busy;
    reg nxt_irq;
    reg [7:0] nxt_rdata;
    reg [9:0] sample;
    // decoded strobes and helpers
    wire wr_mask;
    wire wr_sel;
    wire wr_flags;
    wire wr_mflag;
    wire wr_mmask;
    wire [3:0] lin_flags;
    wire [3:0] lin_stat;
    wire [15:0] acc_sum;
    wire [8:0] avg;
    wire last_sample;
    wire sel_master;
    wire lin_pending;
    wire meas_pending;

    assign wr_mask = reg_wr && (reg_addr == `LMM_ADDR_LIN_MASK);
    assign wr_sel = reg_wr && (reg_addr == `LMM_ADDR_MEAS_SEL);
    assign wr_flags = reg_wr && (reg_addr == `LMM_ADDR_LIN_FLAGS);
    assign wr_mflag = reg_wr && (reg_addr == `LMM_ADDR_MEAS_FLAG);
    assign wr_mmask = reg_wr && (reg_addr == `LMM_ADDR_MEAS_MASK);

    // status follows live levels only
    assign lin_stat = {lin1_pg_in, lin0_pg_in, lin1_oc_in, lin0_oc_in};

    // lin1 power good flag
    lmm_edge_flag u_l1_pg (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(lin1_pg_in),
        .rise_mask(lin_mask_ff[`LMM_BIT_L1_RISE]),
        .fall_mask(lin_mask_ff[`LMM_BIT_L1_FALL]),
        .clr(wr_flags & reg_wdata[`LMM_BIT_L1_PG]),
        .flag_ff(lin_flags[`LMM_BIT_L1_PG])
    );
    // lin0 power good flag
    lmm_edge_flag u_l0_pg (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(lin0_pg_in),
        .rise_mask(lin_mask_ff[`LMM_BIT_L0_RISE]),
        .fall_mask(lin_mask_ff[`LMM_BIT_L0_FALL]),
        .clr(wr_flags & reg_wdata[`LMM_BIT_L0_PG]),
        .flag_ff(lin_flags[`LMM_BIT_L0_PG])
    );
    // lin1 overcurrent flag, rising only
    lmm_edge_flag u_l1_oc (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(lin1_oc_in),
        .rise_mask(lin_mask_ff[`LMM_BIT_L1_OC]),
        .fall_mask(1'b1),
        .clr(wr_flags & reg_wdata[`LMM_BIT_L1_OCF]),
        .flag_ff(lin_flags[`LMM_BIT_L1_OCF])
    );
    // lin0 overcurrent flag, rising only
    lmm_edge_flag u_l0_oc (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(lin0_oc_in),
        .rise_mask(lin_mask_ff[`LMM_BIT_L0_OC]),
        .fall_mask(1'b1),
        .clr(wr_flags & reg_wdata[`LMM_BIT_L0_OCF]),
        .flag_ff(lin_flags[`LMM_BIT_L0_OCF])
    );

    // sample choice by phase role
    assign sel_master = ~buck_dual_phase | (sel_ff == buck1_is_master);
    always @*
    begin
        sample = 10'h000;
        if (buck_dual_phase && sel_master)
            sample = {1'b0, buck0_cur} + {1'b0, buck1_cur};
        else if (sel_ff)
            sample = {1'b0, buck1_cur};
        else
            sample = {1'b0, buck0_cur};
    end

    // running sum holds this cycle's sample too
    assign acc_sum = acc_ff + {6'h00, sample};
    assign last_sample = (state_ff == ST_RUN) && (cnt_ff == 8'h01);
    // divide by 64, saturating at 9 bits
    assign avg = (acc_sum[15:6] > 10'h1ff) ? 9'h1ff : acc_sum[14:6];

    // measurement sequencer
    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_acc = acc_ff;
        nxt_load = load_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (wr_sel)
                begin
                    nxt_state = ST_RUN;
                    nxt_cnt = `LMM_MEAS_CYCLES;
                    nxt_acc = 16'h0000;
                end
            end
            ST_RUN:
            begin
                if (wr_sel)
                begin
                    // restart drops the running window
                    nxt_cnt = `LMM_MEAS_CYCLES;
                    nxt_acc = 16'h0000;
                end
                else if (last_sample)
                begin
                    nxt_state = ST_IDLE;
                    nxt_cnt = 8'h00;
                    nxt_load = avg;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 8'h01;
                    nxt_acc = acc_sum;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt = 8'h00;
            end
        endcase
    end

    // busy follows the sequencer
    always @*
    begin
        nxt_busy = 1'h0;
        if (nxt_state == ST_RUN)
            nxt_busy = 1'h1;
    end

    // ready flag, set wins over clear
    always @*
    begin
        nxt_meas_flag = meas_flag_ff;
        if (last_sample && !wr_sel)
            nxt_meas_flag = 1'h1;
        else if (wr_mflag && reg_wdata[0])
            nxt_meas_flag = 1'h0;
    end

    // interrupt request
    assign lin_pending = |lin_flags;
    assign meas_pending = meas_flag_ff & ~meas_mask_ff;
    always @*
    begin
        nxt_irq = lin_pending | meas_pending;
    end

    // mask registers
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            lin_mask_ff <= `LMM_RST_LIN_MASK;
            meas_mask_ff <= 1'h0;
        end
        else
        begin
            if (wr_mask)
                lin_mask_ff <= reg_wdata & `LMM_LIN_MASK_WMASK;
            if (wr_mmask)
                meas_mask_ff <= reg_wdata[0];
        end
    end

    // select register
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            meas_sel_ff <= `LMM_RST_MEAS_SEL;
            sel_ff <= 1'h0;
        end
        else if (wr_sel)
        begin
            meas_sel_ff <= reg_wdata;
            sel_ff <= reg_wdata[0];
        end
    end

    // measurement engine and result
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            acc_ff <= 16'h0000;
            load_ff <= `LMM_RST_LOAD;
            meas_flag_ff <= 1'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            acc_ff <= nxt_acc;
            load_ff <= nxt_load;
            meas_flag_ff <= nxt_meas_flag;
        end
    end

    // read mux
    always @*
    begin
        case (reg_addr)
            `LMM_ADDR_LIN_MASK: nxt_rdata = lin_mask_ff;
            `LMM_ADDR_MEAS_SEL: nxt_rdata = meas_sel_ff;
            `LMM_ADDR_LOAD_HI: nxt_rdata = {7'h00, load_ff[8]};
            `LMM_ADDR_LOAD_LO: nxt_rdata = load_ff[7:0];
            `LMM_ADDR_LIN_FLAGS: nxt_rdata = {4'h0, lin_flags};
            `LMM_ADDR_LIN_STAT: nxt_rdata = {4'h0, lin_stat};
            `LMM_ADDR_MEAS_FLAG: nxt_rdata = {7'h00, meas_flag_ff};
            `LMM_ADDR_MEAS_MASK: nxt_rdata = {7'h00, meas_mask_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_rdata_ff <= 8'h00;
            irq_ff <= 1'h0;
            meas_busy_ff <= 1'h0;
        end
        else
        begin
            if (reg_rd)
                reg_rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            meas_busy_ff <= nxt_busy;
        end
    end
endmodule // lmm_top

// ---- test/lmm_top_props.sv ----
`timescale 1ns/1ps
module lmm_props (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    // live inputs and state
    input wire lin0_pg_in,
    input wire lin1_pg_in,
    input wire lin0_oc_in,
    input wire lin1_oc_in,
    input wire meas_busy_ff
);
    wire [3:0] live = {lin1_pg_in, lin0_pg_in, lin1_oc_in, lin0_oc_in};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_go;
        reg_wr && reg_addr == 8'h24;
    endsequence
    AST_GO: assert property (s_go |=> meas_busy_ff[*8])
        else $error("no start");
    AST_END: assert property ($rose(meas_busy_ff) |-> ##[8:300] !meas_busy_ff)
        else $error("no end");
    AST_ROSE: assert property ($rose(meas_busy_ff) |-> $past(reg_wr && reg_addr == 8'h24))
        else $error("stray start");
    AST_HI: assert property (s_rd(8'h25) |=> reg_rdata_ff[7:1] == 7'h00)
        else $error("high bits");
    AST_STAT: assert property (s_rd(8'h28) |=> reg_rdata_ff == {4'h0, $past(live)})
        else $error("status");
    AST_RSV: assert property (s_rd(8'h23) |=> !reg_rdata_ff[5] && !reg_rdata_ff[1])
        else $error("mask bits");
    AST_NONE: assert property (s_rd(8'h40) |=> reg_rdata_ff == 8'h00)
        else $error("unmapped");
    AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read hold");
endmodule // lmm_props
bind lmm_top lmm_props i_props (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .lin0_pg_in(lin0_pg_in),
    .lin1_pg_in(lin1_pg_in),
    .lin0_oc_in(lin0_oc_in),
    .lin1_oc_in(lin1_oc_in),
    .meas_busy_ff(meas_busy_ff)
);

// ---- test/tb_ldo_irq_mask_and_load_meter.sv ----
`timescale 1ns/1ps
module tb_ldo_irq_mask_and_load_meter;
    logic ref_clk = 0;
    logic rst = 1;
    logic wr = 0, rd = 0, dual = 0, m1 = 0, irq, busy;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [3:0] live = 0;
    logic [8:0] b0 = 0, b1 = 0, rd_v, e;
    logic [16:0] seed = 17'h17ca2;
    logic [5:0] lv = 6'h36;
    int failures = 0, n_checks = 0, mb[6] = '{7, 6, 4, 3, 2, 0}, ms[6] = '{3, 3, 1, 2, 2, 0};
    lmm_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata_ff(rdata), .lin0_pg_in(live[2]), .lin1_pg_in(live[3]), .lin0_oc_in(live[0]), .lin1_oc_in(live[1]),
        .buck0_cur(b0), .buck1_cur(b1), .buck_dual_phase(dual), .buck1_is_master(m1), .irq_ff(irq), .meas_busy_ff(busy));
    initial forever #12.5 ref_clk = ~ref_clk;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [8:0] exp_cur(input logic sel, logic [8:0] c0, c1);
        logic [9:0] sum;
        sum = c0 + c1;
        if (dual && sel == m1)
            return sum[9] ? 9'h1ff : sum[8:0];
        return sel ? c1 : c0;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic bus(input logic w, logic [7:0] a, d);
        tick(1);
        {wr, rd, addr, wdata} = {w, !w, a, d};
        tick(1);
        {wr, rd} = 2'h0;
        rd_v = {1'b0, rdata};
    endtask
    task automatic chk(input string what, logic [8:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        tick(5);
        rst = 0;
        bus(0, 8'h24, 8'h00);
        chk("select", 9'h000, rd_v);
        bus(1, 8'h23, 8'hff);
        bus(0, 8'h23, 8'h00);
        chk("mask", 9'h0dd, rd_v);
        bus(0, 8'h40, 8'h00);
        chk("unmapped", 9'h000, rd_v);
        for (int i = 0; i < 12; i++)
        begin
            bus(1, 8'h23, 8'hdd);
            live[ms[i / 2]] = !lv[i / 2];
            tick(3);
            bus(1, 8'h27, 8'h0f);
            bus(1, 8'h23, i[0] ? 8'h01 << mb[i / 2] : 8'h00);
            live[ms[i / 2]] = lv[i / 2];
            tick(3);
            chk("irq", {8'h00, !i[0]}, {8'h00, irq});
            bus(0, 8'h27, 8'h00);
            chk("flags", i[0] ? 9'h000 : 9'h001 << ms[i / 2], rd_v);
            bus(0, 8'h28, 8'h00);
            chk("status", {5'h00, live}, rd_v);
        end
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(lfsr(seed));
            b0 = k == 7 ? 9'h1ff : seed[8:0];
            b1 = k == 7 ? 9'h1ff : seed[16:8];
            {dual, m1} = k[2:1];
            e = exp_cur(k[0], b0, b1);
            bus(1, 8'h2a, {7'h00, k[0]});
            bus(1, 8'h24, {7'h00, !k[0]});
            bus(1, 8'h24, {seed[6:0], k[0]});
            bus(0, 8'h24, 8'h00);
            chk("select", {1'b0, seed[6:0], k[0]}, rd_v);
            repeat (300)
                if (busy !== 1'b0)
                    tick(1);
            chk("busy", 9'h000, {8'h00, busy});
            if (busy !== 1'b0)
                break;
            tick(1);
            chk("ready irq", {8'h00, !k[0]}, {8'h00, irq});
            bus(0, 8'h25, 8'h00);
            chk("load high", {8'h00, e[8]}, rd_v);
            bus(0, 8'h26, 8'h00);
            chk("load low", {1'b0, e[7:0]}, rd_v);
            bus(1, 8'h29, 8'h01);
            tick(1);
            chk("irq clear", 9'h000, {8'h00, irq});
        end
        end_of_test();
    end
endmodule // tb_ldo_irq_mask_and_load_meter
